// >>> core/srap_pkg.sv
// Shared constants and types for the serial register access port
package srap_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;

  // Command word layout
  localparam int CMD_EN_LSB = 11;
  localparam int CMD_RW_BIT = 10;
  localparam logic [4:0] SPI_ENABLE = 5'h1C;

  // Address pointer limits
  localparam logic [ADDR_W-1:0] PTR_MAX = 10'h3FF;
  localparam logic [ADDR_W-1:0] PTR_RESET = 10'h000;

  // Bit counting
  localparam logic [3:0] SPI_BIT_LAST = 4'hF;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

  // Fixed upper part of the seven-bit target address
  localparam logic [4:0] I2C_ADDR_HI = 5'h0B;

  // Request to the register file
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } srap_reg_req_t;

  // Write word held for the crossing out of the link domain
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } srap_wr_word_t;

  typedef enum logic [3:0] {
    SP_CMD = 4'h1,
    SP_WR = 4'h2,
    SP_RD = 4'h4,
    SP_IGN = 4'h8
  } srap_spi_st_t;

  typedef enum logic [4:0] {
    IC_IDLE = 5'h01,
    IC_RX = 5'h02,
    IC_ACK = 5'h04,
    IC_TX = 5'h08,
    IC_MACK = 5'h10
  } srap_i2c_st_t;

  typedef enum logic [4:0] {
    K_DEV = 5'h01,
    K_AH = 5'h02,
    K_AL = 5'h04,
    K_DH = 5'h08,
    K_DL = 5'h10
  } srap_byte_kind_t;

  // Saturating pointer advance: the pointer never wraps
  function automatic logic [ADDR_W-1:0] srap_ptr_next(input logic [ADDR_W-1:0] p);
    srap_ptr_next = (p == PTR_MAX) ? p : p + 10'h001;
  endfunction : srap_ptr_next

endpackage : srap_pkg

// >>> core/srap_port.sv
// Serial register access port: SPI slave on its own clock and I2C target
`timescale 1ns/1ns
// Functional notes
// R1: Sample on rising, shift out on falling.
// R2: Master lowers select, sends command first.
// R3: Command top bits 11100 enable transaction.
// R4: Command bit 10: one read, zero write.
// R5: Low ten command bits give start address.
// R6: Each write word stored, pointer then advances.
// R7: Write until select rises; no wrap, discard.
// R8: Master gives sixteen clocks per read word.
// R9: First read bit on first falling edge.
// R10: Reads continue until select goes high.
// R11: Read at maximum repeats last register.
// R12: Data out released unless returning reads.
// R13: Single write needs thirty-two clocks total.
// R14: I2C side is target only.
// R15: Target address 01011 plus two straps.
// R16: Matching address acknowledged on ninth clock.
// R17: Byte is eight bits MSB first plus acknowledge.
// R18: Stop returns idle, pointer to zero.
// R19: Register address sent high then low byte.
// R20: Register data sent high then low byte.
// R21: I2C write pointer advances, never wraps.
// R22: I2C read returns high byte first.
// R23: I2C read past maximum repeats last register.
// R24: Master writes whole 16-bit registers only.
// R25: Early select rise aborts, drops partial word.
// R26: SPI words shifted most significant bit first.
module srap_port
  import srap_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic addr_strap_low,
  input wire logic addr_strap_high,
  output srap_reg_req_t reg_req,
  input wire logic [DATA_W-1:0] reg_rdata
);

  // Link domain (sclk) state
  logic link_rst_r;
  logic [3:0] sp_cnt_r;
  logic [DATA_W-1:0] sp_sh_r;
  srap_spi_st_t sp_st_r;
  logic [ADDR_W-1:0] sp_ptr_r;
  logic sp_end_r;
  logic sp_wr_tog_r;
  logic sp_rd_tog_r;
  srap_wr_word_t sp_wr_lk_r;
  logic [ADDR_W-1:0] sp_rd_addr_r;
  logic [DATA_W-1:0] sp_out_sh_r;
  logic sdo_r;
  logic sdo_oe_r;
  logic [DATA_W-1:0] sp_word;
  logic sp_done;
  logic sp_cmd_ok;

  // System domain state
  logic [2:0] wr_tog_s;
  logic [2:0] rd_tog_s;
  logic [DATA_W-1:0] rd_word_r;
  srap_reg_req_t reg_req_r;
  srap_reg_req_t ic_req_r;

  // I2C state
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [1:0] strap_lo_s;
  logic [1:0] strap_hi_s;
  srap_i2c_st_t ic_st_r;
  srap_byte_kind_t ic_kind_r;
  logic [3:0] ic_cnt_r;
  logic [7:0] ic_sh_r;
  logic [7:0] ic_tx_r;
  logic [1:0] ic_ahi_r;
  logic [7:0] ic_dhi_r;
  logic [ADDR_W-1:0] ic_ptr_r;
  logic ic_end_r;
  logic ic_rw_r;
  logic ic_lo_r;
  logic sda_oe_r;
  logic scl_rise;
  logic scl_fall;
  logic ic_start;
  logic ic_stop;
  logic [7:0] ic_byte;

  // R26 MSB first: new bit enters at the bottom
  assign sp_word = {sp_sh_r[DATA_W-2:0], sdi};
  assign sp_done = (sp_cnt_r == SPI_BIT_LAST);
  // R3 enable pattern gates the transaction
  assign sp_cmd_ok = (sp_word[DATA_W-1:CMD_EN_LSB] == SPI_ENABLE);

  // Held a cycle so link logic leaves reset on a clean edge
  always_ff @(posedge clk_sys)
  begin
    link_rst_r <= srst;
  end

  // R1 sample on rising edge; R25 select rise drops partial word
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      sp_cnt_r <= 4'h0;
      sp_sh_r <= 16'h0000;
      sp_st_r <= SP_CMD;
    end
    else
    begin
      sp_cnt_r <= sp_cnt_r + 4'h1;
      sp_sh_r <= sp_word;
      if (sp_done && sp_st_r == SP_CMD)
      begin
        // R4 direction bit
        if (!sp_cmd_ok)
          sp_st_r <= SP_IGN;
        else if (sp_word[CMD_RW_BIT])
          sp_st_r <= SP_RD;
        else
          sp_st_r <= SP_WR;
      end
    end
  end

  // Address pointer of the link side
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      sp_ptr_r <= PTR_RESET;
      sp_end_r <= 1'b0;
    end
    else if (sp_done && sp_st_r == SP_CMD)
    begin
      // R5 start address
      sp_ptr_r <= sp_word[ADDR_W-1:0];
      sp_end_r <= 1'b0;
    end
    else if (sp_done && sp_st_r == SP_WR && !sp_end_r)
    begin
      // R7 stop accepting once the top register is written
      sp_end_r <= (sp_ptr_r == PTR_MAX);
      sp_ptr_r <= srap_ptr_next(sp_ptr_r);
    end
    else if (sp_st_r == SP_RD && sp_cnt_r == 4'h0)
    begin
      // R11 saturating advance repeats the last register
      sp_ptr_r <= srap_ptr_next(sp_ptr_r);
    end
  end

  // Toggles survive select rising so a finished word still crosses
  always_ff @(posedge sclk or posedge link_rst_r)
  begin
    if (link_rst_r)
    begin
      sp_wr_tog_r <= 1'b0;
      sp_rd_tog_r <= 1'b0;
      sp_wr_lk_r <= '0;
      sp_rd_addr_r <= PTR_RESET;
    end
    else if (!cs_n)
    begin
      if (sp_done && sp_st_r == SP_CMD && sp_cmd_ok && sp_word[CMD_RW_BIT])
      begin
        sp_rd_addr_r <= sp_word[ADDR_W-1:0];
        sp_rd_tog_r <= ~sp_rd_tog_r;
      end
      // R6 store each completed data word until the top register is written
      if (sp_done && sp_st_r == SP_WR && !sp_end_r)
      begin
        sp_wr_lk_r <= '{addr: sp_ptr_r, data: sp_word};
        sp_wr_tog_r <= ~sp_wr_tog_r;
      end
      // R10 prefetch the next word while the current one shifts
      if (sp_st_r == SP_RD && sp_cnt_r == 4'h0)
      begin
        sp_rd_addr_r <= srap_ptr_next(sp_ptr_r);
        sp_rd_tog_r <= ~sp_rd_tog_r;
      end
    end
  end

  // R1 shift out on falling edge; R12 enable only while reading
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
      sp_out_sh_r <= 16'h0000;
    end
    else
    begin
      sdo_oe_r <= (sp_st_r == SP_RD);
      if (sp_cnt_r == 4'h0)
      begin
        // R9 first bit of each word on the edge after the last bit
        sdo_r <= rd_word_r[DATA_W-1];
        sp_out_sh_r <= {rd_word_r[DATA_W-2:0], 1'b0};
      end
      else
      begin
        sdo_r <= sp_out_sh_r[DATA_W-1];
        sp_out_sh_r <= {sp_out_sh_r[DATA_W-2:0], 1'b0};
      end
    end
  end

  // Toggle synchronisers; bit 2 is only the edge history
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wr_tog_s <= 3'h0;
      rd_tog_s <= 3'h0;
    end
    else
    begin
      wr_tog_s <= {wr_tog_s[1:0], sp_wr_tog_r};
      rd_tog_s <= {rd_tog_s[1:0], sp_rd_tog_r};
    end
  end

  // Only one variant is wired in practice, so plain priority suffices
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      reg_req_r <= '0;
    else
    begin
      reg_req_r.wr <= 1'b0;
      reg_req_r.rd <= 1'b0;
      if (wr_tog_s[2] != wr_tog_s[1])
        reg_req_r <= '{wr: 1'b1, rd: 1'b0, addr: sp_wr_lk_r.addr, wdata: sp_wr_lk_r.data};
      else if (rd_tog_s[2] != rd_tog_s[1])
        reg_req_r <= '{wr: 1'b0, rd: 1'b1, addr: sp_rd_addr_r, wdata: 16'h0000};
      else if (ic_req_r.wr || ic_req_r.rd)
        reg_req_r <= ic_req_r;
    end
  end

  // Read data sampled at the end of the strobe cycle
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rd_word_r <= 16'h0000;
    else if (reg_req_r.rd)
      rd_word_r <= reg_rdata;
  end

  // I2C pins and straps pass two flops before use
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      strap_lo_s <= 2'h0;
      strap_hi_s <= 2'h0;
    end
    else
    begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      strap_lo_s <= {strap_lo_s[0], addr_strap_low};
      strap_hi_s <= {strap_hi_s[0], addr_strap_high};
    end
  end

  assign scl_rise = scl_s[1] && !scl_s[2];
  assign scl_fall = !scl_s[1] && scl_s[2];
  assign ic_start = scl_s[1] && scl_s[2] && sda_s[2] && !sda_s[1];
  assign ic_stop = scl_s[1] && scl_s[2] && !sda_s[2] && sda_s[1];
  assign ic_byte = ic_sh_r;

  // R14 target only: the line is merely pulled low, never a start
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ic_st_r <= IC_IDLE;
      ic_kind_r <= K_DEV;
      ic_cnt_r <= 4'h0;
      ic_sh_r <= 8'h00;
      ic_tx_r <= 8'h00;
      ic_ahi_r <= 2'h0;
      ic_dhi_r <= 8'h00;
      ic_ptr_r <= PTR_RESET;
      ic_end_r <= 1'b0;
      ic_rw_r <= 1'b0;
      ic_lo_r <= 1'b0;
      sda_oe_r <= 1'b0;
      ic_req_r <= '0;
    end
    else
    begin
      ic_req_r.wr <= 1'b0;
      ic_req_r.rd <= 1'b0;
      if (ic_stop)
      begin
        // R18 idle and pointer back to zero
        ic_st_r <= IC_IDLE;
        ic_ptr_r <= PTR_RESET;
        ic_end_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end
      else if (ic_start)
      begin
        ic_st_r <= IC_RX;
        ic_kind_r <= K_DEV;
        ic_cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end
      else
      begin
        unique case (ic_st_r)
          IC_IDLE:
            ;
          IC_RX:
            // R17 eight bits MSB first, then acknowledge
            if (scl_rise)
            begin
              ic_sh_r <= {ic_sh_r[6:0], sda_s[1]};
              ic_cnt_r <= ic_cnt_r + 4'h1;
            end
            else if (scl_fall && ic_cnt_r == I2C_BYTE_BITS)
            begin
              ic_cnt_r <= 4'h0;
              ic_st_r <= IC_ACK;
              sda_oe_r <= 1'b1;
              unique case (ic_kind_r)
                K_DEV:
                  // R15 R16 acknowledge only our own address
                  if (ic_byte[7:1] == {I2C_ADDR_HI, strap_hi_s[1], strap_lo_s[1]})
                  begin
                    ic_rw_r <= ic_byte[0];
                    ic_lo_r <= 1'b0;
                    ic_kind_r <= K_AH;
                    if (ic_byte[0])
                      ic_req_r <= '{wr: 1'b0, rd: 1'b1, addr: ic_ptr_r, wdata: 16'h0000};
                  end
                  else
                  begin
                    ic_st_r <= IC_IDLE;
                    sda_oe_r <= 1'b0;
                  end
                K_AH:
                begin
                  // R19 upper address byte keeps only two bits
                  ic_ahi_r <= ic_byte[1:0];
                  ic_kind_r <= K_AL;
                end
                K_AL:
                begin
                  ic_ptr_r <= {ic_ahi_r, ic_byte};
                  ic_end_r <= 1'b0;
                  ic_kind_r <= K_DH;
                end
                K_DH:
                begin
                  // R20 R24 bytes pair high then low
                  ic_dhi_r <= ic_byte;
                  ic_kind_r <= K_DL;
                end
                K_DL:
                begin
                  ic_kind_r <= K_DH;
                  // R21 advance after each register, discard past the top
                  if (!ic_end_r)
                  begin
                    ic_req_r <= '{wr: 1'b1, rd: 1'b0, addr: ic_ptr_r, wdata: {ic_dhi_r, ic_byte}};
                    ic_end_r <= (ic_ptr_r == PTR_MAX);
                    ic_ptr_r <= srap_ptr_next(ic_ptr_r);
                  end
                end
                default:
                  ic_kind_r <= K_DEV;
              endcase
            end
          IC_ACK:
            if (scl_fall)
            begin
              ic_cnt_r <= 4'h0;
              if (ic_rw_r)
              begin
                // R22 high byte of the register first
                ic_st_r <= IC_TX;
                sda_oe_r <= ~rd_word_r[DATA_W-1];
                ic_tx_r <= {rd_word_r[DATA_W-2:8], 1'b0};
              end
              else
              begin
                ic_st_r <= IC_RX;
                sda_oe_r <= 1'b0;
              end
            end
          IC_TX:
            if (scl_rise)
              ic_cnt_r <= ic_cnt_r + 4'h1;
            else if (scl_fall)
            begin
              if (ic_cnt_r == I2C_BYTE_BITS)
              begin
                ic_st_r <= IC_MACK;
                sda_oe_r <= 1'b0;
              end
              else
              begin
                sda_oe_r <= ~ic_tx_r[7];
                ic_tx_r <= {ic_tx_r[6:0], 1'b0};
              end
            end
          IC_MACK:
            if (scl_rise && sda_s[1])
              // Not-acknowledge ends the read; wait for stop or restart
              ic_st_r <= IC_IDLE;
            else if (scl_fall)
            begin
              ic_st_r <= IC_TX;
              ic_cnt_r <= 4'h0;
              ic_lo_r <= ~ic_lo_r;
              if (!ic_lo_r)
              begin
                // R23 fetch next word; saturates at the top
                sda_oe_r <= ~rd_word_r[7];
                ic_tx_r <= {rd_word_r[6:0], 1'b0};
                ic_ptr_r <= srap_ptr_next(ic_ptr_r);
                ic_req_r <= '{wr: 1'b0, rd: 1'b1, addr: srap_ptr_next(ic_ptr_r),
                  wdata: 16'h0000};
              end
              else
              begin
                sda_oe_r <= ~rd_word_r[DATA_W-1];
                ic_tx_r <= {rd_word_r[DATA_W-2:8], 1'b0};
              end
            end
          default:
            ic_st_r <= IC_IDLE;
        endcase
      end
    end
  end

  // Open drain: output value is always low, the enable pulls the line
  always_ff @(posedge clk_sys)
  begin
    sda_o <= 1'b0;
  end

  assign sdo = sdo_r;
  assign sdo_oe = sdo_oe_r;
  assign sda_oe = sda_oe_r;
  assign reg_req = reg_req_r;

endmodule : srap_port

// >>> dv/srap_port_monitor.sv
// Checker on the pins of the serial register access port
`timescale 1ns/1ns
module srap_port_monitor
  import srap_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo_oe,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire srap_reg_req_t reg_req
);
  logic [4:0] cnt_r;
  logic [15:0] cmd_r;
  logic rd_cmd;
  // Raised select clears the frame, as it does in the port
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      cnt_r <= 5'h00;
      cmd_r <= 16'h0000;
    end
    else if (cnt_r != 5'h10)
    begin
      cnt_r <= cnt_r + 5'h01;
      cmd_r <= {cmd_r[14:0], sdi};
    end
  end
  assign rd_cmd = (cnt_r == 5'h10) && (cmd_r[15:11] == SPI_ENABLE) && cmd_r[CMD_RW_BIT];

  a_sda_only_low: assert property (@(posedge clk_sys) disable iff (srst) sda_o == 1'b0)
    else $error("sda_o high");
  a_sda_scl_low: assert property (@(posedge clk_sys) disable iff (srst)
    $changed(sda_oe) |-> !scl_i && !$past(scl_i)) else $error("sda moved, scl high");
  a_oe_idle_cs: assert property (@(posedge clk_sys) disable iff (srst) cs_n |-> !sdo_oe)
    else $error("sdo driven, no frame");
  a_wr_one_cycle: assert property (@(posedge clk_sys) disable iff (srst)
    reg_req.wr |=> !reg_req.wr && $stable(reg_req.addr)) else $error("write pulse");
  a_rd_one_cycle: assert property (@(posedge clk_sys) disable iff (srst)
    reg_req.rd |=> !reg_req.rd) else $error("read pulse");
  a_wr_rd_apart: assert property (@(posedge clk_sys) disable iff (srst)
    !(reg_req.wr && reg_req.rd)) else $error("read and write together");
  a_rd_oe_on: assert property (@(negedge sclk) disable iff (cs_n) rd_cmd |=> sdo_oe)
    else $error("sdo not driven in read");
  a_oe_needs_rd: assert property (@(negedge sclk) disable iff (cs_n) sdo_oe |-> rd_cmd)
    else $error("sdo driven without read");
  c_write: cover property (@(posedge clk_sys) disable iff (srst) reg_req.wr);
  c_read: cover property (@(posedge clk_sys) disable iff (srst) reg_req.rd);
  c_ack: cover property (@(posedge clk_sys) disable iff (srst) $rose(sda_oe));
endmodule : srap_port_monitor

bind srap_port srap_port_monitor mon_u (
  .clk_sys(clk_sys), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_oe(sdo_oe),
  .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .reg_req(reg_req)
);

// >>> dv/srap_host.sv
// Host model: SPI master and I2C master facing the port
`timescale 1ns/1ns
module srap_host (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  output logic scl_i,
  output wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe
);
  localparam int HALF = 32;
  localparam int T = 200;
  logic hd;
  time wend;
  // Pulled-up line: low when either side pulls it
  assign sda_i = hd & (sda_oe ? sda_o : 1'b1);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b0;
    sdi = 1'b0;
    scl_i = 1'b1;
    hd = 1'b1;
    wend = 0;
    // A clean rise of select clears the frame logic before the first frame
    #1 cs_n = 1'b1;
  end
  // set in low phase, most significant first
  task automatic spi_bits(input logic [15:0] tx, input int n, input int tail,
                          output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 15; i > 15 - n; i--)
    begin
      sdi = tx[i];
      #HALF sclk = 1'b1;
      rx = {rx[14:0], sdo};
      if (i == 0)
        wend = $time;
      #(i == 0 ? tail : HALF) sclk = 1'b0;
    end
  endtask : spi_bits
  task automatic spi_end();
    #HALF cs_n = 1'b1;
    // Released line shows the inverse, never a stale bit
    sdi = ~sdi;
    #(2 * HALF);
  endtask : spi_end
  // command first, sixteen clocks per word
  task automatic spi_frame(input logic [15:0] cmd, input logic [63:0] dat, input int nw,
                           output logic [63:0] got);
    logic [15:0] rx;
    got = 64'h0;
    cs_n = 1'b0;
    #HALF;
    // First read word needs time to cross into the link domain
    spi_bits(cmd, 16, 160, rx);
    for (int k = 0; k < nw; k++)
    begin
      spi_bits(dat[63 - 16 * k -: 16], 16, HALF, rx);
      got = {got[47:0], rx};
    end
    spi_end();
    #200;
  endtask : spi_frame
  // data changes only while the clock is low
  task automatic i2c_bit(input logic b, output logic r);
    #T hd = b;
    #T scl_i = 1'b1;
    #T r = sda_i;
    scl_i = 1'b0;
  endtask : i2c_bit
  task automatic i2c_byte(input logic [7:0] tx, input logic ack_in,
                          output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      i2c_bit(tx[i], r);
      rx[i] = r;
    end
    i2c_bit(ack_in, ack);
  endtask : i2c_byte
  task automatic i2c_start();
    #T hd = 1'b1;
    #T scl_i = 1'b1;
    #T hd = 1'b0;
    #T scl_i = 1'b0;
  endtask : i2c_start
  task automatic i2c_stop();
    #T hd = 1'b0;
    #T scl_i = 1'b1;
    #T hd = 1'b1;
    #T;
  endtask : i2c_stop
endmodule : srap_host

// >>> dv/serial_register_access_port_test.sv
// Self-checking testbench for the serial register access port
`timescale 1ns/1ns
module serial_register_access_port_test
  import srap_pkg::*;
;
  logic clk_sys;
  logic srst;
  logic strap_h;
  logic strap_l;
  wire sclk, cs_n, sdi, scl_i, sda_i;
  logic sdo, sdo_oe, sda_o, sda_oe;
  srap_reg_req_t reg_req;
  logic [DATA_W-1:0] reg_rdata;
  srap_wr_word_t wq[$];
  int nrd = 0;
  int miscompares = 0;
  int tests_run = 0;

  function automatic logic [15:0] rdat(input logic [9:0] a);
    rdat = {a[5:0], a} ^ 16'h5A00;
  endfunction : rdat
  assign reg_rdata = rdat(reg_req.addr);

  srap_port dut_u (
    .clk_sys(clk_sys), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_strap_low(strap_l), .addr_strap_high(strap_h), .reg_req(reg_req),
    .reg_rdata(reg_rdata)
  );
  srap_host host_u (
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_oe ? sdo : ~sdo), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  // Sampled mid-cycle, well clear of the edge that launches the strobes
  always @(negedge clk_sys)
  begin
    if (reg_req.wr === 1'b1)
    begin
      wq.push_back({reg_req.addr, reg_req.wdata});
      if ($time - host_u.wend < 1000)
        chk(($time - host_u.wend) inside {[40:120]}, "write latency");
    end
    if (reg_req.rd === 1'b1)
      nrd++;
  end

  task automatic t_spi_write();
    logic [63:0] got;
    wq.delete();
    host_u.spi_frame(16'hE3FE, 64'h1234_5678_9ABC_0000, 3, got);
    chk(wq.size() == 2, "write count");
    chk(wq[0] === {10'h3FE, 16'h1234}, "first word");
    chk(wq[1] === {10'h3FF, 16'h5678}, "second word");
    $display("done: spi_write");
  endtask : t_spi_write

  task automatic t_spi_abort();
    logic [15:0] rx;
    logic [63:0] got;
    wq.delete();
    host_u.cs_n = 1'b0;
    host_u.spi_bits(16'hE010, 16, 32, rx);
    host_u.spi_bits(16'hFFFF, 9, 32, rx);
    host_u.spi_end();
    host_u.spi_frame(16'hE011, {16'hC3A5, 48'h0}, 1, got);
    chk(wq.size() == 1 && wq[0] === {10'h011, 16'hC3A5}, "after abort");
    $display("done: spi_abort");
  endtask : t_spi_abort

  task automatic t_spi_bad();
    logic [63:0] got;
    logic [15:0] bad [3] = '{16'hF020, 16'hF420, 16'hEC20};
    wq.delete();
    nrd = 0;
    foreach (bad[i])
      host_u.spi_frame(bad[i], 64'h1111_2222_0000_0000, 2, got);
    chk(wq.size() == 0 && nrd == 0, "bad enable acted on");
    $display("done: spi_bad");
  endtask : t_spi_bad

  task automatic t_spi_read();
    logic [63:0] got;
    logic [47:0] exp;
    exp = {rdat(10'h3FE), rdat(10'h3FF), rdat(10'h3FF)};
    host_u.spi_frame(16'hE7FE, 64'h0, 3, got);
    chk(got[47:0] === exp, "read words");
    chk(sdo_oe === 1'b0, "sdo still driven");
    $display("done: spi_read");
  endtask : t_spi_read

  task automatic wb(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic ack;
    host_u.i2c_byte(b, 1'b1, rx, ack);
    chk(ack === exp_ack, "acknowledge");
  endtask : wb

  task automatic rb(input logic ack_in, input logic [7:0] exp);
    logic [7:0] rx;
    logic ack;
    host_u.i2c_byte(8'hFF, ack_in, rx, ack);
    chk(rx === exp, "read byte");
  endtask : rb

  task automatic t_i2c();
    logic [15:0] w;
    wq.delete();
    host_u.i2c_start();
    wb(8'h5A, 1'b1);
    host_u.i2c_stop();
    host_u.i2c_start();
    wb(8'h5C, 1'b0);
    wb(8'hFD, 1'b0);
    wb(8'h23, 1'b0);
    wb(8'hBE, 1'b0);
    wb(8'hEF, 1'b0);
    repeat (8) @(negedge clk_sys);
    chk(wq.size() == 1 && wq[0] === {10'h123, 16'hBEEF}, "i2c write");
    host_u.i2c_start();
    wb(8'h5D, 1'b0);
    w = rdat(10'h124);
    rb(1'b0, w[15:8]);
    rb(1'b1, w[7:0]);
    host_u.i2c_stop();
    host_u.i2c_start();
    wb(8'h5D, 1'b0);
    w = rdat(10'h000);
    rb(1'b0, w[15:8]);
    rb(1'b1, w[7:0]);
    host_u.i2c_stop();
    $display("done: i2c");
  endtask : t_i2c

  task automatic t_i2c_top();
    logic [15:0] w;
    wq.delete();
    w = rdat(10'h3FF);
    host_u.i2c_start();
    wb(8'h5C, 1'b0);
    wb(8'h03, 1'b0);
    wb(8'hFF, 1'b0);
    wb(8'h12, 1'b0);
    wb(8'h34, 1'b0);
    wb(8'h56, 1'b0);
    wb(8'h78, 1'b0);
    host_u.i2c_start();
    wb(8'h5D, 1'b0);
    rb(1'b0, w[15:8]);
    rb(1'b0, w[7:0]);
    rb(1'b0, w[15:8]);
    rb(1'b1, w[7:0]);
    host_u.i2c_stop();
    chk(wq.size() == 1 && wq[0] === {10'h3FF, 16'h1234}, "i2c top write");
    $display("done: i2c_top");
  endtask : t_i2c_top

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial
  begin
    srst = 1'b1;
    strap_h = 1'b1;
    strap_l = 1'b0;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    repeat (4) @(negedge clk_sys);
    t_spi_write();
    t_spi_abort();
    t_spi_bad();
    t_spi_read();
    t_i2c();
    t_i2c_top();
    finish_test();
  end

  initial
  begin
    #400000;
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end
endmodule : serial_register_access_port_test
